// ===== design/tmr_top.sv
// buffered 16-bit timer/counter base with an apb register slave
// How it works
// [RQ1] counter, period, compares and buffers are 16-bit
// [RQ2] split mode runs two 8-bit counters
// [RQ3] bottom means counter equals zero
// [RQ4] max means counter all ones
// [RQ5] top means counter equals period
// [RQ6] update copies valid buffers unless lock set
// [RQ7] trigger effects appear on next tick
// [RQ8] tick from prescaled clock or events
// [RQ9] counter compared continuously with zero, period
// [RQ10] enable starts counting at prescaler rate
// [RQ11] count-on-event counts event inputs instead
// [RQ12] counting up wraps to zero after top
// [RQ13] counting down reloads period at bottom
// [RQ14] counter write is immediate and wins
// [RQ15] direction change accepted while running
// [RQ16] period and compares have flagged buffers
// [RQ17] buffer write sets flag, update clears it
// [RQ18] compare and its buffer both writable
// [RQ19] events may steer direction or restart
// [RQ20] unbuffered period write takes effect immediately
// [RQ21] low period written runs counter to wrap
// [RQ22] all updates synchronous, counting only on ticks
// [RQ23] wrap and reload raise overflow, underflow flags
`include "tmr_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tmr_top
    import tmr_pkg::*;
#(
    parameter logic [15:0] PER_RESET = `TMR_PER_RST // period after reset
) (
    input  wire logic        pclk,             // 50 MHz clock
    input  wire logic        presetn,          // async reset, low
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb access phase
    input  wire logic        pwrite,           // apb write
    input  wire logic [7:0]  paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    output logic      [31:0] prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb error
    input  wire logic        count_event_in,   // counting event
    input  wire logic        dir_event_in,     // direction event
    input  wire logic        restart_event_in, // restart event
    output logic      [5:0]  compare_event,    // compare match pulses
    output logic             ovf_event,        // overflow pulse
    output logic             unf_event,        // underflow pulse
    output logic             hi_wrap_event,    // split high wrap
    output logic             update_event      // update pulse
);
    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    // a zero period puts top on bottom and makes update ambiguous
    if (PER_RESET == `TMR_ZERO16) begin : g_bad_per
        $error("PER_RESET must be non-zero");
    end

    // ----------------------------------------------------------------
    // state and helpers
    // ----------------------------------------------------------------
    tmr_state_s s;         // registered state, 16-bit words [RQ1]
    tmr_state_s nxt_s;     // next state
    logic [9:0]  ps_mask;  // prescaler mask
    logic        en;       // enable bit
    logic        split;    // split mode bit
    logic        tick;     // qualified timer_tick
    logic        down;     // effective direction down
    logic [2:0]  rise;     // synced rising edges
    logic        restart;  // qualified restart
    logic        wrap;     // low or full counter wrapped
    logic        upd;      // update condition
    logic        wr;       // apb write strobe
    logic        hit;      // address is mapped
    logic [16:0] r_lo;     // step result low or full
    logic [16:0] r_hi;     // step result high half
    logic        at_bot;   // bottom
    logic        at_max;   // max
    logic        at_top;   // top
    tmr_dir_e    dir;      // direction as enum

    // one counting step: wrap flag and next value
    function automatic logic [16:0] tmr_step(
        input logic [15:0] v,
        input logic [15:0] top,
        input logic [15:0] maxv,
        input logic        dn
    );
        logic [16:0] res;
        res = {1'b0, v};
        if (dn) begin
            // reload with period on bottom
            if (v == `TMR_ZERO16) res = {1'b1, top}; // [RQ13]
            else res = {1'b0, v - 16'h0001};
        end else begin
            // past max the count also wraps, so a low period
            // written under the count runs on to the wrap
            if (v == top || v == maxv) begin
                res = {1'b1, `TMR_ZERO16}; // [RQ12] [RQ21]
            end else begin
                res = {1'b0, v + 16'h0001};
            end
        end
        return res;
    endfunction : tmr_step

    // ----------------------------------------------------------------
    // decode and status
    // ----------------------------------------------------------------
    // control fields
    assign en    = s.ctrl_a[`TMR_A_EN];
    assign split = s.ctrl_a[`TMR_A_SPLIT];
    // edge logic compares the second stage with the third
    assign rise  = s.sy2 & ~s.sy3;
    // event level may override the direction bit
    assign down  = s.evctl[`TMR_V_DIREI] ? s.sy2[1] :
                   s.ctrl_e[`TMR_E_DOWN]; // [RQ15] [RQ19]
    assign dir   = down ? TMR_DOWN : TMR_UP;
    // continuous compares, low byte only in split mode
    assign at_bot = split ? (s.cnt[7:0] == 8'h00) :
                    (s.cnt == `TMR_ZERO16); // [RQ3] [RQ9]
    assign at_max = split ? (s.cnt[7:0] == 8'hFF) :
                    (s.cnt == `TMR_MAX16); // [RQ4]
    assign at_top = split ? (s.cnt[7:0] == s.per[7:0]) :
                    (s.cnt == s.per); // [RQ5] [RQ9]
    // apb is zero wait state
    assign pready = 1'b1;
    assign wr     = psel && penable && pwrite;
    assign prdata = s.rdata;

    // prescaler mask from clock_select
    always_comb begin
        case (s.ctrl_a[`TMR_A_CS_HI:`TMR_A_CS_LO])
            3'h0:    ps_mask = 10'h000;
            3'h1:    ps_mask = 10'h001;
            3'h2:    ps_mask = 10'h003;
            3'h3:    ps_mask = 10'h007;
            3'h4:    ps_mask = 10'h00F;
            3'h5:    ps_mask = 10'h03F;
            3'h6:    ps_mask = 10'h0FF;
            default: ps_mask = 10'h3FF;
        endcase
    end

    // tick source, gated by enable
    assign tick = en && (s.evctl[`TMR_V_COUNT_ON_EVENT_ENABLE] ? rise[0] :
                  ((s.pre & ps_mask) == ps_mask)); // [RQ8] [RQ10] [RQ11]
    assign restart = en && s.evctl[`TMR_V_RSTEI] && rise[2]; // [RQ19]

    // counting steps for full or split operation
    always_comb begin
        if (split) begin
            // two 8-bit halves sharing the direction
            r_lo = tmr_step({8'h00, s.cnt[7:0]},
                            {8'h00, s.per[7:0]}, `TMR_MAX8,
                            down); // [RQ2]
            r_hi = tmr_step({8'h00, s.cnt[15:8]},
                            {8'h00, s.per[15:8]}, `TMR_MAX8,
                            down); // [RQ2]
        end else begin
            r_lo = tmr_step(s.cnt, s.per, `TMR_MAX16, down);
            r_hi = 17'h00000;
        end
    end
    assign wrap = tick && r_lo[16];
    // update at top or at the wrap, as control_e selects
    assign upd  = s.ctrl_e[`TMR_E_UPDTOP] ? (tick && at_top) : wrap;

    // mapped address check
    always_comb begin
        hit = (paddr <= `TMR_A_CMPBUF0 + 8'h08) &&
              (paddr[1:0] == 2'b00);
    end
    assign pslverr = psel && penable && !hit;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] set_f;  // flags set this cycle
        logic [2:0] clr_f;  // flags cleared by software
        logic [7:0] a;      // address of a compare slot
        set_f = 3'h0;
        clr_f = 3'h0;
        a     = 8'h00;
        nxt_s = s;
        // synchronisers for event inputs
        nxt_s.sy1 = {restart_event_in, dir_event_in, count_event_in};
        nxt_s.sy2 = s.sy1;
        nxt_s.sy3 = s.sy2;
        // prescaler runs only while enabled
        nxt_s.pre = en ? s.pre + 10'h001 : 10'h000;
        // pulses last one cycle
        nxt_s.cmp_ev = 6'h00;
        nxt_s.ovf_ev = 1'b0;
        nxt_s.unf_ev = 1'b0;
        nxt_s.hi_ev  = 1'b0;
        nxt_s.upd_ev = upd;
        // counting happens only on qualified ticks
        if (tick) begin
            nxt_s.cnt = split ? {r_hi[7:0], r_lo[7:0]} :
                        r_lo[15:0]; // [RQ22]
            // trigger seen now shows on this tick's edge
            nxt_s.ovf_ev = r_lo[16] && !down; // [RQ7] [RQ23]
            nxt_s.unf_ev = r_lo[16] && down;  // [RQ7] [RQ23]
            nxt_s.hi_ev  = split && r_hi[16];
            for (int i = 0; i < `TMR_NCMP; i++) begin
                if (split) begin
                    nxt_s.cmp_ev[i] =
                        s.cnt[7:0] == s.cmp[i][7:0]; // [RQ2] [RQ7]
                    nxt_s.cmp_ev[i+3] =
                        s.cnt[15:8] == s.cmp[i][15:8]; // [RQ2]
                end else begin
                    nxt_s.cmp_ev[i] = s.cnt == s.cmp[i]; // [RQ7]
                end
            end
        end
        // restart event restarts the sequence
        if (restart) begin
            nxt_s.cnt = (dir == TMR_DOWN) ? s.per : `TMR_ZERO16;
        end
        // copy valid buffers at update unless locked
        if (upd && !s.ctrl_e[`TMR_E_LOCK_UPDATE]) begin
            if (s.per_bv) begin
                nxt_s.per    = s.per_buf; // [RQ6]
                nxt_s.per_bv = 1'b0;      // [RQ17]
            end
            for (int i = 0; i < `TMR_NCMP; i++) begin
                if (s.cmp_bv[i]) begin
                    nxt_s.cmp[i]    = s.cmp_buf[i]; // [RQ6]
                    nxt_s.cmp_bv[i] = 1'b0;         // [RQ17]
                end
            end
        end
        // software writes follow counting and update so they win, except a status clear against a flag set
        if (wr && hit) begin
            case (paddr)
                `TMR_A_CONTROL_A:  nxt_s.ctrl_a = pwdata[4:0];
                `TMR_A_CONTROL_E:  nxt_s.ctrl_e = pwdata[2:0]; // [RQ15]
                `TMR_A_EVENT_CONTROL: nxt_s.evctl = pwdata[2:0];
                `TMR_A_STATUS: clr_f = pwdata[2:0];
                `TMR_A_CNT:    nxt_s.cnt = pwdata[15:0]; // [RQ14]
                `TMR_A_PER:    nxt_s.per = pwdata[15:0]; // [RQ20]
                `TMR_A_PERIOD_BUFFER: begin
                    nxt_s.per_buf = pwdata[15:0]; // [RQ16]
                    nxt_s.per_bv  = 1'b1;         // [RQ17]
                end
                default: begin
                    // compare slots and their buffers
                    for (int i = 0; i < `TMR_NCMP; i++) begin
                        a = `TMR_A_CMP0 + 8'(i * `TMR_A_STEP);
                        if (paddr == a) begin
                            nxt_s.cmp[i] = pwdata[15:0]; // [RQ18]
                        end
                        a = `TMR_A_CMPBUF0 + 8'(i * `TMR_A_STEP);
                        if (paddr == a) begin
                            nxt_s.cmp_buf[i] = pwdata[15:0]; // [RQ18]
                            nxt_s.cmp_bv[i]  = 1'b1; // [RQ16] [RQ17]
                        end
                    end
                end
            endcase
        end
        // sticky flags: a set in the clear cycle survives
        set_f = {nxt_s.hi_ev, nxt_s.unf_ev, nxt_s.ovf_ev};
        nxt_s.flags = (s.flags & ~clr_f) | set_f; // [RQ23]
        // read data captured in the setup phase
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `TMR_A_CONTROL_A:  nxt_s.rdata = {27'h0, s.ctrl_a};
                `TMR_A_CONTROL_E:  nxt_s.rdata = {29'h0, s.ctrl_e};
                `TMR_A_EVENT_CONTROL: nxt_s.rdata = {29'h0, s.evctl};
                `TMR_A_CONTROL_F:  nxt_s.rdata = {28'h0, s.cmp_bv,
                                              s.per_bv};
                `TMR_A_STATUS: nxt_s.rdata = {26'h0, at_max, at_bot,
                                              at_top, s.flags};
                `TMR_A_CNT:    nxt_s.rdata = {16'h0, s.cnt};
                `TMR_A_PER:    nxt_s.rdata = {16'h0, s.per};
                `TMR_A_PERIOD_BUFFER: nxt_s.rdata = {16'h0, s.per_buf};
                default: begin
                    nxt_s.rdata = 32'h00000000;
                    for (int i = 0; i < `TMR_NCMP; i++) begin
                        a = `TMR_A_CMP0 + 8'(i * `TMR_A_STEP);
                        if (paddr == a) begin
                            nxt_s.rdata = {16'h0, s.cmp[i]};
                        end
                        a = `TMR_A_CMPBUF0 + 8'(i * `TMR_A_STEP);
                        if (paddr == a) begin
                            nxt_s.rdata = {16'h0, s.cmp_buf[i]};
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s     <= '0;
            s.per <= PER_RESET;
        end else begin
            s <= nxt_s; // [RQ22]
        end
    end

    // event outputs straight from flops
    assign compare_event = s.cmp_ev;
    assign ovf_event     = s.ovf_ev;
    assign unf_event     = s.unf_ev;
    assign hi_wrap_event = s.hi_ev;
    assign update_event  = s.upd_ev;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_cnt; // software counter write
    logic wr_per; // software period write
    assign wr_cnt = wr && paddr == `TMR_A_CNT;
    assign wr_per = wr && paddr == `TMR_A_PER;

    sequence ovf_pulse_s;
        ovf_event ##1 !ovf_event;
    endsequence

    up_wrap_zero_a: assert property ( // [RQ12]
        tick && !split && !down && s.cnt == s.per && !wr_cnt &&
        !restart |=> s.cnt == `TMR_ZERO16)
        else $error("counter did not wrap to zero at top");
    down_reload_a: assert property ( // [RQ13]
        tick && !split && down && s.cnt == `TMR_ZERO16 && !wr_cnt &&
        !restart |=> s.cnt == $past(s.per))
        else $error("counter did not reload the period");
    cnt_write_wins_a: assert property ( // [RQ14]
        wr_cnt |=> s.cnt == $past(pwdata[15:0]))
        else $error("counter write lost");
    hold_no_tick_a: assert property ( // [RQ22]
        !tick && !restart && !wr_cnt |=> $stable(s.cnt))
        else $error("counter moved without a tick");
    ovf_next_tick_a: assert property ( // [RQ7]
        wrap && !down |=> ovf_pulse_s)
        else $error("overflow pulse missing or too long");
    bv_set_write_a: assert property ( // [RQ17]
        wr && paddr == `TMR_A_PERIOD_BUFFER |=> s.per_bv)
        else $error("period buffer flag not set");
    update_copy_a: assert property ( // [RQ6]
        upd && !s.ctrl_e[`TMR_E_LOCK_UPDATE] && s.per_bv && !wr_per
        |=> s.per == $past(s.per_buf))
        else $error("buffered period not copied");
    lock_hold_a: assert property ( // [RQ6]
        upd && s.ctrl_e[`TMR_E_LOCK_UPDATE] && !wr_per |=> $stable(s.per))
        else $error("period changed while update locked");
    per_direct_a: assert property ( // [RQ20]
        wr_per |=> s.per == $past(pwdata[15:0]))
        else $error("period write not immediate");
    full_rate_a: assert property ( // [RQ10]
        en && s.ctrl_a[`TMR_A_CS_HI:`TMR_A_CS_LO] == 3'h0 &&
        !s.evctl[`TMR_V_COUNT_ON_EVENT_ENABLE] |-> tick)
        else $error("no tick at undivided rate");
    flag_set_wins_a: assert property ( // [RQ23]
        ovf_event |-> s.flags[0])
        else $error("overflow flag lost");
endmodule : tmr_top
`default_nettype wire

// ===== design/tmr_consts.svh
// named offsets, field positions and reset values of the timer block
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define TMR_A_CONTROL_A   8'h00
`define TMR_A_CONTROL_E   8'h04
`define TMR_A_EVENT_CONTROL  8'h08
`define TMR_A_CONTROL_F   8'h0C
`define TMR_A_STATUS  8'h10
`define TMR_A_CNT     8'h14
`define TMR_A_PER     8'h18
`define TMR_A_PERIOD_BUFFER  8'h1C
`define TMR_A_CMP0    8'h20
`define TMR_A_CMPBUF0 8'h2C
`define TMR_A_STEP    8'h04
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TMR_A_EN      0
`define TMR_A_CS_LO   1
`define TMR_A_CS_HI   3
`define TMR_A_SPLIT   4
`define TMR_E_DOWN    0
`define TMR_E_LOCK_UPDATE    1
`define TMR_E_UPDTOP  2
`define TMR_V_COUNT_ON_EVENT_ENABLE   0
`define TMR_V_DIREI   1
`define TMR_V_RSTEI   2
// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define TMR_ZERO16    16'h0000
`define TMR_MAX16     16'hFFFF
`define TMR_MAX8      16'h00FF
`define TMR_PER_RST   16'hFFFF
`define TMR_PS_W      10
`define TMR_NCMP      3
`endif

// ===== design/tmr_pkg.sv
// types shared by the timer block
package tmr_pkg;
    // count direction after event steering
    typedef enum logic {TMR_UP, TMR_DOWN} tmr_dir_e;
    // whole state of the timer, registered in one process
    typedef struct packed {
        logic [2:0][15:0] cmp;     // compare_value 0..2
        logic [2:0][15:0] cmp_buf; // compare_buffer 0..2
        logic [2:0]       cmp_bv;  // compare_buffer_valid
        logic [15:0]      cnt;     // counter
        logic [15:0]      per;     // period
        logic [15:0]      per_buf; // period_buffer
        logic             per_bv;  // period_buffer_valid
        logic [4:0]       ctrl_a;  // control_a
        logic [2:0]       ctrl_e;  // control_e
        logic [2:0]       evctl;   // event_control
        logic [2:0]       flags;   // sticky ovf, unf, high wrap
        logic [9:0]       pre;     // prescaler count
        logic [2:0]       sy1;     // first sync stage
        logic [2:0]       sy2;     // second sync stage
        logic [2:0]       sy3;     // previous synced level
        logic [5:0]       cmp_ev;  // compare event pulses
        logic             ovf_ev;  // overflow pulse
        logic             unf_ev;  // underflow pulse
        logic             hi_ev;   // high half wrap pulse
        logic             upd_ev;  // update pulse
        logic [31:0]      rdata;   // read data register
    } tmr_state_s;
endpackage : tmr_pkg

// ===== tb/tb_tmr_top.sv
// self-checking bench for the buffered 16-bit timer block
`include "tmr_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_tmr_top;
    import tmr_pkg::*;
    // ----------------------------------------------------------------
    // signals and bookkeeping
    // ----------------------------------------------------------------
    typedef struct {
        logic [32:0] exp;   // slave error above read data
        logic [31:0] msk;   // read bits that are judged
    } tmr_note_s;
    logic        pclk = 1'b0;       // 50 MHz bench clock
    logic        presetn = 1'b0;    // held low for ten cycles
    logic        psel = 1'b0;       // apb select
    logic        penable = 1'b0;    // apb access phase
    logic        pwrite = 1'b0;     // apb direction
    logic [7:0]  paddr = 8'h00;     // apb address
    logic [31:0] pwdata = 32'h0;    // apb write data
    logic [31:0] prdata;            // apb read data
    logic        pready;            // apb ready
    logic        pslverr;           // apb error
    logic        count_event_in = 1'b0;   // counting event
    logic        dir_event_in = 1'b0;     // direction event
    logic        restart_event_in = 1'b0; // restart event
    logic [5:0]  compare_event;     // compare pulses
    logic        ovf_event;         // wrap pulse
    logic        unf_event;         // reload pulse
    logic        hi_wrap_event;     // split high wrap pulse
    logic        update_event;      // update pulse
    int          n_cmp, n_upd, n_hi, n_ov; // pulse counts
    int          c0;                // count snapshot
    tmr_note_s   notes[$];          // expected reads, oldest first
    tmr_note_s   cur;               // note being judged
    int          n_errors = 0;      // mismatches seen
    int          n_compared = 0;    // comparisons made
    int          nc;                // cycles between two pulses
    logic [15:0] v;                 // random counter value
    int          cs[4] = '{0, 1, 2, 5};   // clock_select codes tried
    int          dv[4] = '{1, 2, 4, 64};  // their divide ratios

    always #10 pclk = ~pclk;

    tmr_top tmr_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_event_in(count_event_in), .dir_event_in(dir_event_in),
        .restart_event_in(restart_event_in),
        .compare_event(compare_event), .ovf_event(ovf_event),
        .unf_event(unf_event), .hi_wrap_event(hi_wrap_event),
        .update_event(update_event)
    );

    // ----------------------------------------------------------------
    // verdict and compares
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_rd(input logic [7:0] a, input logic [32:0] e,
                          input logic [32:0] g, input logic [31:0] m);
        n_compared++;
        if ((g & {1'b1, m}) !== (e & {1'b1, m})) begin
            n_errors++;
            $display("[FAIL] read %h exp %h got %h", a, e, g);
        end
    endtask : chk_rd

    task automatic chk_int(input int e, input int g);
        n_compared++;
        if (e != g) begin
            n_errors++;
            $display("[FAIL] pulse interval exp %0d got %0d", e, g);
        end
    endtask : chk_int

    // watcher: judges every completed read against the oldest note
    always @(posedge pclk) begin
        // counters move after the edge, so snapshots never race
        n_cmp <= n_cmp + compare_event[1];
        n_upd <= n_upd + update_event;
        n_hi  <= n_hi + hi_wrap_event;
        n_ov  <= n_ov + ovf_event;
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (notes.size() == 0) begin
                n_errors++;
                $display("[FAIL] read %h exp none got %h", paddr, prdata);
            end else begin
                cur = notes.pop_front();
                chk_rd(paddr, cur.exp, {pslverr, prdata}, cur.msk);
            end
        end
    end

    // ----------------------------------------------------------------
    // bus and event drivers
    // ----------------------------------------------------------------
    // one apb transfer; an edge passes before a new setup begins
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [32:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF);
        notes.push_back('{e, m});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // counts cycles up to the next wrap or reload pulse, bounded
    task automatic wait_pulse(input logic dn, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((dn ? unf_event : ovf_event) !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            n_errors++;
            report_and_stop();
        end
    endtask : wait_pulse

    // wide pulses, since the inputs pass a synchroniser first
    task automatic pulses(input int k);
        repeat (k) begin
            count_event_in <= 1'b1;
            repeat (4) @(posedge pclk);
            count_event_in <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask : pulses

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hFBDC3EC6));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TMR_A_PER, 33'h0_0000_FFFF);
        rd(`TMR_A_CNT, 33'h0);
        rd(`TMR_A_CONTROL_F, 33'h0);
        rd(`TMR_A_STATUS, 33'h10);
        rd(8'h40, 33'h1_0000_0000);
        wr(`TMR_A_CONTROL_F, 32'hF);
        rd(`TMR_A_CONTROL_F, 33'h0);
        repeat (4) begin
            v = 16'($urandom);
            wr(`TMR_A_CNT, {16'h0, v});
            rd(`TMR_A_CNT, {17'h0, v});
        end
        wr(`TMR_A_CNT, 32'hFFFF);
        rd(`TMR_A_STATUS, 33'h28);
        // wrap spacing is twice the divide ratio with a period of one
        wr(`TMR_A_PER, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(`TMR_A_CNT, 32'h0);
            wr(`TMR_A_CONTROL_A, 32'(cs[i] * 2 + 1));
            wait_pulse(1'b0, nc);
            wait_pulse(1'b0, nc);
            chk_int(2 * dv[i], nc);
            wr(`TMR_A_CONTROL_A, 32'h0);
        end
        // buffered period and compare copied at the wrap
        wr(`TMR_A_STATUS, 32'h7);
        wr(`TMR_A_PER, 32'h3);
        wr(`TMR_A_PERIOD_BUFFER, 32'h6);
        wr(`TMR_A_CMPBUF0, 32'h22);
        wr(`TMR_A_CMP0, 32'h11);
        rd(`TMR_A_CONTROL_F, 33'h3);
        rd(`TMR_A_CMP0, 33'h11);
        wr(`TMR_A_CNT, 32'h0);
        c0 = n_upd;
        wr(`TMR_A_CONTROL_A, 32'h1);
        wait_pulse(1'b0, nc);
        wr(`TMR_A_CONTROL_A, 32'h0);
        rd(`TMR_A_PER, 33'h6);
        rd(`TMR_A_CMP0, 33'h22);
        rd(`TMR_A_CONTROL_F, 33'h0);
        rd(`TMR_A_STATUS, 33'h1, 32'h7);
        chk_int(1, n_upd - c0);
        // counting down with the update locked
        wr(`TMR_A_STATUS, 32'h7);
        wr(`TMR_A_CONTROL_E, 32'h3);
        wr(`TMR_A_PERIOD_BUFFER, 32'h2);
        wr(`TMR_A_CNT, 32'h0);
        wr(`TMR_A_CONTROL_A, 32'h1);
        wait_pulse(1'b1, nc);
        wr(`TMR_A_CONTROL_A, 32'h0);
        rd(`TMR_A_PER, 33'h6);
        rd(`TMR_A_CONTROL_F, 33'h1);
        rd(`TMR_A_STATUS, 33'h2, 32'h3);
        // counting events, then down under the direction event
        wr(`TMR_A_CONTROL_E, 32'h0);
        wr(`TMR_A_PER, 32'hFFFF);
        wr(`TMR_A_CNT, 32'h0);
        wr(`TMR_A_CMP0 + `TMR_A_STEP, 32'h3);
        c0 = n_cmp;
        wr(`TMR_A_EVENT_CONTROL, 32'h1);
        wr(`TMR_A_CONTROL_A, 32'h1);
        pulses(5);
        rd(`TMR_A_CNT, 33'h5);
        wr(`TMR_A_EVENT_CONTROL, 32'h3);
        dir_event_in <= 1'b1;
        pulses(2);
        rd(`TMR_A_CNT, 33'h3);
        chk_int(1, n_cmp - c0);
        // restart edge with direction event off clears the count
        wr(`TMR_A_EVENT_CONTROL, 32'h5);
        restart_event_in <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(`TMR_A_CNT, 33'h0);
        // split halves with period one wrap together
        wr(`TMR_A_CONTROL_A, 32'h0);
        wr(`TMR_A_EVENT_CONTROL, 32'h0);
        wr(`TMR_A_CONTROL_E, 32'h2);
        wr(`TMR_A_PER, 32'h0101);
        wr(`TMR_A_CNT, 32'h0);
        wr(`TMR_A_STATUS, 32'h7);
        c0 = n_hi - n_ov;
        wr(`TMR_A_CONTROL_A, 32'h11);
        repeat (8) @(posedge pclk);
        wr(`TMR_A_CONTROL_A, 32'h0);
        rd(`TMR_A_STATUS, 33'h5, 32'h7);
        chk_int(c0, n_hi - n_ov);
        report_and_stop();
    end

    // hang guard: a run this long counts as a mismatch
    initial begin
        #(20 * 100000);
        n_errors++;
        report_and_stop();
    end
endmodule : tb_tmr_top
`default_nettype wire
